// *** include/rtc_date_pkg.sv ***
// Package of register offsets, field layouts and types for the alarm and date register block
package rtc_date_pkg;
    // Register offsets (16-bit registers, word-indexed)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_ALARM_CFG = 4'h1;
    localparam logic [3:0] OFS_ALARM_VAL = 4'h2;
    localparam logic [3:0] OFS_YEAR = 4'h3;
    localparam logic [3:0] OFS_MONTH_DAY = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;

    // Control register bits
    localparam int CTL_UNLOCK_BIT = 0;
    localparam int CTL_RUN_BIT = 1;

    // Alarm configuration fields
    localparam int ACFG_REPEAT_LSB = 0;
    localparam int ACFG_PTR_LSB = 8;
    localparam int ACFG_MASK_LSB = 10;
    localparam int ACFG_CHIME_BIT = 14;
    localparam int ACFG_ENABLE_BIT = 15;

    // Alarm period codes
    localparam logic [3:0] ALARM_PERIOD_MASK_HALF_SEC = 4'h0;
    localparam logic [3:0] ALARM_PERIOD_MASK_TEN_MIN = 4'h4;
    localparam logic [3:0] ALARM_PERIOD_MASK_HOUR = 4'h5;
    localparam logic [3:0] ALARM_PERIOD_MASK_LAST_VALID = 4'h9;

    // Window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WDAY_HOUR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_NONE = 2'h3;

    // Implemented bits of the date registers
    localparam logic [15:0] YEAR_MASK = 16'h00FF;
    localparam logic [15:0] MONTH_DAY_MASK = 16'h1F3F;
    localparam logic [15:0] WDAY_HOUR_MASK = 16'h073F;
    localparam logic [15:0] MIN_SEC_MASK = 16'h7F7F;

    // Interrupt status bits
    localparam int IRQ_REJECT_BIT = 0;
    localparam int IRQ_ALARM_BIT = 1;
    localparam logic [15:0] IRQ_FIELD_MASK = 16'h0003;

    // Alarm configuration as a packed struct
    typedef struct packed {
        logic enable;
        logic chime;
        logic [3:0] period_mask;
        logic [1:0] window_pointer;
        logic [7:0] repeat_count;
    } alarm_cfg_s;

    // Register access request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
endpackage

// *** hw/rtc_date_regs.sv ***
// Alarm configuration, year and month/day registers with write unlock and interrupt
module rtc_date_regs (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Alarm event from the timebase comparator (same clock)
    input wire logic ALARM_MATCH,
    // Block state
    output logic RUN_ENABLE,
    output logic ALARM_ENABLE,
    output logic [3:0] ALARM_PERIOD,
    output logic ALARM_FIRE,
    output logic IRQ
);

    // All block state in one struct
    typedef struct packed {
        logic unlock;
        logic run;
        rtc_date_pkg::alarm_cfg_s cfg;
        logic [15:0] alm_md;
        logic [15:0] alm_wh;
        logic [15:0] alm_ms;
        logic [15:0] year;
        logic [15:0] month_day;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic fire;
        logic [15:0] rdata;
    } state_s;

    state_s s_q;
    state_s s_d;
    rtc_date_pkg::bus_req_s req;
    logic [15:0] win_val;
    logic wr_locked;

    // Request bundle
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // Alarm value visible through the window
    always_comb begin
        case (s_q.cfg.window_pointer)
            rtc_date_pkg::PTR_MIN_SEC: win_val = s_q.alm_ms;
            rtc_date_pkg::PTR_WDAY_HOUR: win_val = s_q.alm_wh;
            rtc_date_pkg::PTR_MONTH_DAY: win_val = s_q.alm_md;
            default: win_val = 16'h0000;
        endcase
    end

    // Attempted write to a guarded register while locked
    assign wr_locked = req.wr && !s_q.unlock
        && (req.addr == rtc_date_pkg::OFS_YEAR || req.addr == rtc_date_pkg::OFS_MONTH_DAY);

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.fire = 1'b0;
        s_d.rdata = 16'h0000;
        // Alarm event handling with repeat countdown
        if (ALARM_MATCH && s_q.cfg.enable) begin
            s_d.fire = 1'b1;
            s_d.irq_status[rtc_date_pkg::IRQ_ALARM_BIT] = 1'b1;
            if (s_q.cfg.repeat_count != 8'h00) begin
                s_d.cfg.repeat_count = s_q.cfg.repeat_count - 8'h01;
            end else if (s_q.cfg.chime) begin
                s_d.cfg.repeat_count = 8'hFF;
            end else begin
                s_d.cfg.enable = 1'b0;
            end
        end
        // Register writes
        if (req.wr) begin
            case (req.addr)
                rtc_date_pkg::OFS_CONTROL: begin
                    s_d.unlock = req.wdata[rtc_date_pkg::CTL_UNLOCK_BIT];
                    if (s_q.unlock) begin
                        s_d.run = req.wdata[rtc_date_pkg::CTL_RUN_BIT];
                    end
                end
                rtc_date_pkg::OFS_ALARM_CFG: begin
                    s_d.cfg = rtc_date_pkg::alarm_cfg_s'(req.wdata);
                end
                rtc_date_pkg::OFS_ALARM_VAL: begin
                    // write through window then step pointer
                    case (s_q.cfg.window_pointer)
                        rtc_date_pkg::PTR_MIN_SEC:
                            s_d.alm_ms = req.wdata & rtc_date_pkg::MIN_SEC_MASK;
                        rtc_date_pkg::PTR_WDAY_HOUR:
                            s_d.alm_wh = req.wdata & rtc_date_pkg::WDAY_HOUR_MASK;
                        rtc_date_pkg::PTR_MONTH_DAY:
                            s_d.alm_md = req.wdata & rtc_date_pkg::MONTH_DAY_MASK;
                        default: ;
                    endcase
                    if (s_q.cfg.window_pointer != rtc_date_pkg::PTR_MIN_SEC) begin
                        s_d.cfg.window_pointer = s_q.cfg.window_pointer - 2'h1;
                    end
                end
                rtc_date_pkg::OFS_YEAR: begin
                    if (s_q.unlock) begin
                        s_d.year = req.wdata & rtc_date_pkg::YEAR_MASK;
                    end
                end
                rtc_date_pkg::OFS_MONTH_DAY: begin
                    if (s_q.unlock) begin
                        s_d.month_day = req.wdata & rtc_date_pkg::MONTH_DAY_MASK;
                    end
                end
                rtc_date_pkg::OFS_IRQ_MASK: begin
                    s_d.irq_mask = req.wdata[1:0];
                end
                default: ;
            endcase
        end
        // Reads
        if (req.rd) begin
            case (req.addr)
                rtc_date_pkg::OFS_CONTROL: begin
                    s_d.rdata[rtc_date_pkg::CTL_UNLOCK_BIT] = s_q.unlock;
                    s_d.rdata[rtc_date_pkg::CTL_RUN_BIT] = s_q.run;
                end
                rtc_date_pkg::OFS_ALARM_CFG: s_d.rdata = 16'(s_q.cfg);
                rtc_date_pkg::OFS_ALARM_VAL: begin
                    s_d.rdata = win_val;
                    if (s_q.cfg.window_pointer != rtc_date_pkg::PTR_MIN_SEC) begin
                        s_d.cfg.window_pointer = s_q.cfg.window_pointer - 2'h1;
                    end
                end
                rtc_date_pkg::OFS_YEAR: s_d.rdata = s_q.year & rtc_date_pkg::YEAR_MASK;
                rtc_date_pkg::OFS_MONTH_DAY:
                    s_d.rdata = s_q.month_day & rtc_date_pkg::MONTH_DAY_MASK;
                rtc_date_pkg::OFS_IRQ_STATUS: begin
                    s_d.rdata = {14'h0000, s_q.irq_status};
                    // Read clears, but events this cycle still set
                    s_d.irq_status = 2'h0;
                end
                rtc_date_pkg::OFS_IRQ_MASK: s_d.rdata = {14'h0000, s_q.irq_mask};
                default: s_d.rdata = 16'h0000;
            endcase
        end
        // Sticky sets win over read-clear
        if (wr_locked) begin
            s_d.irq_status[rtc_date_pkg::IRQ_REJECT_BIT] = 1'b1;
        end
        if (ALARM_MATCH && s_q.cfg.enable) begin
            s_d.irq_status[rtc_date_pkg::IRQ_ALARM_BIT] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign RDATA = s_q.rdata;
    assign RUN_ENABLE = s_q.run;
    assign ALARM_ENABLE = s_q.cfg.enable;
    assign ALARM_PERIOD = s_q.cfg.period_mask;
    assign ALARM_FIRE = s_q.fire;
    assign IRQ = |(s_q.irq_status & s_q.irq_mask);

endmodule

// *** testbench/rtc_date_regs_assertions.sv ***
// Concurrent checks on the alarm and date register block ports
module rtc_date_regs_assertions (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // Alarm and run state
    input wire logic ALARM_MATCH,
    input wire logic RUN_ENABLE,
    input wire logic ALARM_ENABLE,
    input wire logic [3:0] ALARM_PERIOD,
    input wire logic ALARM_FIRE
);
    logic unlock_q;
    logic [7:0] year_q;
    logic ctl_wr;
    assign ctl_wr = WR && ADDR == rtc_date_pkg::OFS_CONTROL;
    // Shadow of the unlock bit and of the year digits
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            unlock_q <= 1'b0;
            year_q <= 8'h00;
        end else begin
            if (ctl_wr) unlock_q <= WDATA[0];
            if (WR && ADDR == rtc_date_pkg::OFS_YEAR && unlock_q) year_q <= WDATA[7:0];
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    property p_year_read; $past(RD) && $past(ADDR) == 4'h3 |-> RDATA == {8'h00, year_q}; endproperty
    a_year_read: assert property (p_year_read) else $error("year readback wrong");
    property p_mday_pad; $past(RD) && $past(ADDR) == 4'h4 |-> (RDATA & 16'hE0C0) == 16'h0000; endproperty
    a_mday_pad: assert property (p_mday_pad) else $error("month/day pad bits set");
    property p_run_locked; ctl_wr && !unlock_q |=> $stable(RUN_ENABLE); endproperty
    a_run_locked: assert property (p_run_locked) else $error("run changed while locked");
    property p_run_write; ctl_wr && unlock_q |=> RUN_ENABLE == $past(WDATA[1]); endproperty
    a_run_write: assert property (p_run_write) else $error("run write lost");
    property p_period; WR && ADDR == 4'h1 |=> ALARM_PERIOD == $past(WDATA[13:10]); endproperty
    a_period: assert property (p_period) else $error("period mask wrong");
    property p_fire; ALARM_MATCH && ALARM_ENABLE |=> ALARM_FIRE; endproperty
    a_fire: assert property (p_fire) else $error("alarm did not fire");
    property p_cause; ALARM_FIRE |-> $past(ALARM_MATCH) && $past(ALARM_ENABLE); endproperty
    a_cause: assert property (p_cause) else $error("alarm fired without cause");
    property p_cfg_en; WR && ADDR == 4'h1 && !ALARM_MATCH |=> ALARM_ENABLE == $past(WDATA[15]); endproperty
    a_cfg_en: assert property (p_cfg_en) else $error("alarm enable not loaded");
endmodule
bind rtc_date_regs rtc_date_regs_assertions rtc_date_regs_assertions_i (.*);

// *** testbench/tb.sv ***
// Self-checking bench for the alarm and date register block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_s;
    logic clock, arst_n, wr, rd, alarm_match, run_enable, alarm_enable, alarm_fire, irq;
    logic [3:0] addr;
    logic [3:0] alarm_period;
    logic [15:0] wdata;
    logic [15:0] rdata;
    int err_total;
    int compares;
    row_s rows [8];
    rtc_date_regs rtc_date_regs_i (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .ALARM_MATCH(alarm_match), .RUN_ENABLE(run_enable),
        .ALARM_ENABLE(alarm_enable), .ALARM_PERIOD(alarm_period), .ALARM_FIRE(alarm_fire),
        .IRQ(irq));
    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic get(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check("rdata", rdata, e);
    endtask
    task automatic pulse;
        alarm_match <= 1'b1;
        @(posedge clock);
        alarm_match <= 1'b0;
        #1;
        check("fire", {15'h0000, alarm_fire}, 16'h0001);
    endtask
    // Main sequence
    initial begin
        {arst_n, wr, rd, alarm_match, addr, wdata, err_total, compares} = '0;
        rows = '{'{4'h3, 16'hFF00, 16'h0000}, '{4'h3, 16'h1299, 16'h0099},
            '{4'h4, 16'hFFFF, 16'h1F3F}, '{4'h4, 16'h1239, 16'h1239},
            '{4'h1, 16'h1000, 16'h1000}, '{4'h1, 16'h1400, 16'h1400},
            '{4'h1, 16'h00FF, 16'h00FF}, '{4'h1, 16'h0000, 16'h0000}};
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        get(4'h3, 16'h0000);
        put(4'h0, 16'h0001);
        foreach (rows[i]) begin
            put(rows[i].a, rows[i].d);
            get(rows[i].a, rows[i].e);
        end
        put(4'h0, 16'h0000);
        put(4'h6, 16'h0000);
        put(4'h3, 16'h0055);
        get(4'h3, 16'h0099);
        put(4'h4, 16'h0001);
        get(4'h4, 16'h1239);
        check("irq", {15'h0000, irq}, 16'h0000);
        put(4'h6, 16'h0003);
        check("irq", {15'h0000, irq}, 16'h0001);
        get(4'h5, 16'h0001);
        check("irq", {15'h0000, irq}, 16'h0000);
        put(4'h0, 16'h0002);
        check("run", {15'h0000, run_enable}, 16'h0000);
        put(4'h0, 16'h0001);
        put(4'h0, 16'h0003);
        check("run", {15'h0000, run_enable}, 16'h0001);
        put(4'h1, 16'h0200);
        put(4'h2, 16'hFFFF);
        get(4'h1, 16'h0100);
        get(4'h2, 16'h0000);
        get(4'h1, 16'h0000);
        put(4'h1, 16'h0200);
        get(4'h2, 16'h1F3F);
        get(4'h1, 16'h0100);
        put(4'h1, 16'h0300);
        get(4'h2, 16'h0000);
        get(4'h1, 16'h0200);
        get(4'hF, 16'h0000);
        put(4'h1, 16'h8001);
        pulse();
        get(4'h1, 16'h8000);
        pulse();
        get(4'h1, 16'h0000);
        put(4'h1, 16'hC000);
        pulse();
        get(4'h1, 16'hC0FF);
        get(4'h5, 16'h0002);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        get(4'h4, 16'h0000);
        conclude();
    end
endmodule
